// *** src/advo_outputs.sv ***
// acceleration and velocity-step output registers with a read port
// assumes filtered samples, decimation and select come from same-clock logic
`timescale 1ns/1ns
`default_nettype none
module advo_outputs #(
	parameter int unsigned P_INT_SAMPLE_CYCLES = advo_pkg::INT_SAMPLE_CYCLES  // internal sample period
) (
	input  wire logic                   i_mclk,                   // 250 MHz clock
	input  wire logic                   i_reset_n,                // async reset, active low
	input  wire advo_pkg::advo_axis_s   i_accel_x,                // filtered x sample
	input  wire advo_pkg::advo_axis_s   i_accel_y,                // filtered y sample
	input  wire advo_pkg::advo_axis_s   i_accel_z,                // filtered z sample
	input  wire logic [15:0]            i_decimation_setting,     // samples per cycle minus one
	input  wire logic [15:0]            i_misc_control_register,  // select in [3:2]
	input  wire logic                   i_ext_sample_clk,         // external sample clock pin
	input  wire logic                   i_rd_strobe,              // read request
	input  wire logic [6:0]             i_rd_addr,                // read offset
	input  wire logic                   i_wr_strobe,              // write request
	input  wire logic [6:0]             i_wr_addr,                // write offset
	input  wire logic [15:0]            i_wr_data,                // write data
	output logic [15:0]                 o_rd_data,                // read data
	output logic                        o_rd_valid,               // read data valid pulse
	output logic                        o_update                  // registers refreshed pulse
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	advo_pkg::advo_top_state_s st_reg;     // current state
	advo_pkg::advo_top_state_s st_next;    // next state
	advo_pkg::advo_axis_s [2:0] samp;      // live samples per axis
	logic             ext_rise;            // external clock edge
	logic             int_tick;            // internal sample tick
	logic             sel_internal;        // internal clock selected
	logic             sample;              // sample strobe
	logic             last;                // sample closes the cycle
	logic [2:0]       acc_done;            // divide finished per axis
	logic [2:0][15:0] acc_result;          // mean per axis
	logic             wr_ignored;          // writes have no effect

	assign samp         = {i_accel_z, i_accel_y, i_accel_x};
	assign sel_internal = i_misc_control_register[advo_pkg::SEL_LSB +: 2] == advo_pkg::SEL_INTERNAL;
	assign int_tick     = st_reg.tick_cnt == 32'(P_INT_SAMPLE_CYCLES - 1);
	// select chooses the sample rate source
	assign sample       = sel_internal ? int_tick : ext_rise;
	// a cycle spans decimation plus one samples; not an equality, so lowering the
	// setting mid-cycle closes the cycle at the next sample instead of waiting for a 16-bit wrap
	assign last         = st_reg.dec_cnt >= i_decimation_setting;
	assign wr_ignored   = i_wr_strobe & (i_wr_addr != 7'h00) & (|i_wr_data | ~|i_wr_data);

	// ----------------------------------------------------------------
	// external sample clock synchroniser
	// ----------------------------------------------------------------
	advo_pin_sync u_ext_sync (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_pin     (i_ext_sample_clk),
		.o_level   (),
		.o_rise    (ext_rise)
	);

	// ----------------------------------------------------------------
	// per-axis velocity step accumulators
	// ----------------------------------------------------------------
	for (genvar a = 0; a < 3; a++)
	begin : g_axis
		advo_axis_acc u_acc (
			.i_mclk    (i_mclk),
			.i_reset_n (i_reset_n),
			.i_add     (sample && st_reg.fsm == advo_pkg::ST_ACCUM),
			.i_last    (last),
			.i_value   (samp[a].primary),
			.i_divisor (17'(i_decimation_setting) + 17'h00001),
			.o_done    (acc_done[a]),
			.o_result  (acc_result[a])
		);
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next        = st_reg;
		st_next.update = 1'b0;
		st_next.rd     = '0;
		// internal 2048 Hz divider runs free
		st_next.tick_cnt = int_tick ? 32'h00000000 : 32'(st_reg.tick_cnt + 32'h00000001);
		case (st_reg.fsm)
			advo_pkg::ST_ACCUM:
			begin
				// count samples; the last one snapshots and starts the divide
				if (sample)
				begin
					if (last)
					begin
						st_next.dec_cnt = '0;
						st_next.snap    = samp;
						st_next.fsm     = advo_pkg::ST_DIV;
					end
					else
						st_next.dec_cnt = 16'(st_reg.dec_cnt + 16'h0001);
				end
			end
			advo_pkg::ST_DIV:
			begin
				// axes divide in lockstep; samples here are dropped
				if (acc_done[0])
					st_next.fsm = advo_pkg::ST_COMMIT;
			end
			advo_pkg::ST_COMMIT:
			begin
				// every word of every axis refreshes in one edge
				st_next.accel  = st_reg.snap;
				st_next.vel    = acc_result;
				st_next.update = 1'b1;
				st_next.seen   = 1'b1;
				st_next.fsm    = advo_pkg::ST_ACCUM;
			end
			default:
				st_next.fsm = advo_pkg::ST_ACCUM;
		endcase
		// read decode; writes never reach the state
		if (i_rd_strobe)
		begin
			st_next.rd.valid = 1'b1;
			case (i_rd_addr)
				advo_pkg::OFS_ACCEL_X_EXTENSION: st_next.rd.data = st_reg.accel[0].extension;
				advo_pkg::OFS_ACCEL_X_PRIMARY:   st_next.rd.data = st_reg.accel[0].primary;
				advo_pkg::OFS_ACCEL_Y_EXTENSION: st_next.rd.data = st_reg.accel[1].extension;
				advo_pkg::OFS_ACCEL_Y_PRIMARY:   st_next.rd.data = st_reg.accel[1].primary;
				advo_pkg::OFS_ACCEL_Z_EXTENSION: st_next.rd.data = st_reg.accel[2].extension;
				advo_pkg::OFS_ACCEL_Z_PRIMARY:   st_next.rd.data = st_reg.accel[2].primary;
				advo_pkg::OFS_VELOCITY_STEP_X:   st_next.rd.data = st_reg.vel[0];
				advo_pkg::OFS_VELOCITY_STEP_Y:   st_next.rd.data = st_reg.vel[1];
				advo_pkg::OFS_VELOCITY_STEP_Z:   st_next.rd.data = st_reg.vel[2];
				default:                         st_next.rd.data = advo_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// zero words read as 0x0000 until the first cycle completes
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			st_reg     <= '0;
			st_reg.fsm <= advo_pkg::ST_ACCUM;
		end
		else
			st_reg <= st_next;
	end

	assign o_rd_data  = st_reg.rd.data;
	assign o_rd_valid = st_reg.rd.valid;
	assign o_update   = st_reg.update;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_reset_n);

	property p_zero_before_update;
		!st_reg.seen |-> (st_reg.accel[0].primary == advo_pkg::WORD_ZERO && st_reg.vel[0] == advo_pkg::WORD_ZERO);
	endproperty
	a_zero_before_update: assert property (p_zero_before_update) else $error("word not zero before first update");

	// the snapshot must not move while the divide runs or the commit is pending,
	// else primary and extension words could come from different samples
	property p_snap_hold;
		st_reg.fsm != advo_pkg::ST_ACCUM |=> $stable(st_reg.snap);
	endproperty
	a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved during divide");

	property p_commit_together;
		(st_reg.fsm == advo_pkg::ST_ACCUM && sample && last) |=> ##[1:40] (o_update
			&& st_reg.accel[1].primary == $past(st_reg.snap[1].primary)
			&& st_reg.accel[1].extension == $past(st_reg.snap[1].extension));
	endproperty
	a_commit_together: assert property (p_commit_together) else $error("axis words not committed together");

	property p_ext_value;
		o_update |-> st_reg.accel[2].extension == st_reg.snap[2].extension;
	endproperty
	a_ext_value: assert property (p_ext_value) else $error("extension word differs from sample");

	property p_vel_commit;
		st_reg.fsm == advo_pkg::ST_COMMIT |=> o_update && st_reg.vel == $past(acc_result);
	endproperty
	a_vel_commit: assert property (p_vel_commit) else $error("velocity step not committed");

	property p_cycle_length;
		(st_reg.fsm == advo_pkg::ST_ACCUM && sample && !last) |=> st_reg.dec_cnt == $past(st_reg.dec_cnt) + 16'h0001;
	endproperty
	a_cycle_length: assert property (p_cycle_length) else $error("sample count did not advance");

	property p_select_source;
		!sel_internal && !ext_rise |-> !sample;
	endproperty
	a_select_source: assert property (p_select_source) else $error("sample taken without external edge");

	property p_internal_rate;
		sel_internal && int_tick |=> !int_tick [*2];
	endproperty
	a_internal_rate: assert property (p_internal_rate) else $error("internal tick too frequent");

	property p_read_x_primary;
		i_rd_strobe && i_rd_addr == advo_pkg::OFS_ACCEL_X_PRIMARY |=> o_rd_valid && o_rd_data == $past(st_reg.accel[0].primary);
	endproperty
	a_read_x_primary: assert property (p_read_x_primary) else $error("x primary read wrong");

	property p_read_ext;
		i_rd_strobe && i_rd_addr == advo_pkg::OFS_ACCEL_Y_EXTENSION |=> o_rd_data == $past(st_reg.accel[1].extension);
	endproperty
	a_read_ext: assert property (p_read_ext) else $error("y extension read wrong");

	property p_read_vel;
		i_rd_strobe && i_rd_addr == advo_pkg::OFS_VELOCITY_STEP_Z |=> o_rd_data == $past(st_reg.vel[2]);
	endproperty
	a_read_vel: assert property (p_read_vel) else $error("z velocity step read wrong");

	property p_read_x_ext;
		i_rd_strobe && i_rd_addr == advo_pkg::OFS_ACCEL_X_EXTENSION |=> o_rd_data == $past(st_reg.accel[0].extension);
	endproperty
	a_read_x_ext: assert property (p_read_x_ext) else $error("x extension read wrong");

	property p_write_ignored;
		wr_ignored && st_reg.fsm != advo_pkg::ST_COMMIT |=> $stable(st_reg.accel) && $stable(st_reg.vel);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("write altered an output word");

	c_update:   cover property (o_update);
	c_ext_mode: cover property (!sel_internal && ext_rise ##[1:1000] o_update);
	c_read_vel: cover property (o_update ##[1:20] (i_rd_strobe && i_rd_addr == advo_pkg::OFS_VELOCITY_STEP_X));
endmodule : advo_outputs
`default_nettype wire

// *** src/advo_pkg.sv ***
// constants, state types and carriers for the acceleration and velocity output block
// assumes a single 250 MHz clock and a register port driven by same-clock logic
//
// Contract
// - primary word: signed, 0.25 mg, zero is 0x0000
// - extension word: sixteen bits below the primary
// - one velocity step register per axis
// - velocity step signed, scaled by decimation plus one
// - select 00 uses internal 2048 Hz, else external
// - primaries at 0x12, 0x16, 0x1A
// - y, z extensions at 0x14, 0x18
// - velocity steps at 0x2A, 0x2C, 0x2E
// - all these registers are read only
// - x extension at 0x10, read only
package advo_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [6:0] OFS_ACCEL_X_EXTENSION = 7'h10;
	localparam logic [6:0] OFS_ACCEL_X_PRIMARY   = 7'h12;
	localparam logic [6:0] OFS_ACCEL_Y_EXTENSION = 7'h14;
	localparam logic [6:0] OFS_ACCEL_Y_PRIMARY   = 7'h16;
	localparam logic [6:0] OFS_ACCEL_Z_EXTENSION = 7'h18;
	localparam logic [6:0] OFS_ACCEL_Z_PRIMARY   = 7'h1A;
	localparam logic [6:0] OFS_VELOCITY_STEP_X   = 7'h2A;
	localparam logic [6:0] OFS_VELOCITY_STEP_Y   = 7'h2C;
	localparam logic [6:0] OFS_VELOCITY_STEP_Z   = 7'h2E;
	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int          SEL_LSB       = 2;     // sample clock select field [3:2]
	localparam logic [1:0]  SEL_INTERNAL  = 2'h0;
	localparam logic [15:0] WORD_ZERO     = 16'h0000;
	localparam logic [15:0] UNMAPPED_READ = 16'h0000;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ            = 250_000_000;
	localparam int INT_SAMPLE_HZ     = 2048;
	localparam int INT_SAMPLE_CYCLES = CLK_HZ / INT_SAMPLE_HZ;
	localparam int DIV_STEPS         = 32;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_ACCUM  = 3'b001,
		ST_DIV    = 3'b010,
		ST_COMMIT = 3'b100
	} advo_fsm_e;
	// filtered sample of one axis: primary word over its extension
	typedef struct packed {
		logic [15:0] primary;
		logic [15:0] extension;
	} advo_axis_s;
	// register port answer
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} advo_rd_s;
	// state of the per-axis accumulator and divider
	typedef struct packed {
		logic signed [32:0] acc;
		logic               neg;
		logic [31:0]        quot;
		logic [16:0]        rem;
		logic [16:0]        divisor;
		logic [5:0]         steps;
		logic               busy;
		logic               done;
		logic [15:0]        result;
	} advo_acc_state_s;
	// state of the pin synchroniser
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic edge_p;
	} advo_sync_state_s;
	// state of the top block
	typedef struct packed {
		advo_fsm_e         fsm;
		logic [31:0]       tick_cnt;
		logic [15:0]       dec_cnt;
		advo_axis_s [2:0]  snap;
		advo_axis_s [2:0]  accel;
		logic [2:0][15:0]  vel;
		advo_rd_s          rd;
		logic              update;
		logic              seen;
	} advo_top_state_s;
endpackage : advo_pkg

// *** src/advo_pin_sync.sv ***
// three-stage synchroniser for a pin, with a rising-edge pulse
// assumes the pin is asynchronous to i_mclk
`timescale 1ns/1ns
`default_nettype none
module advo_pin_sync (
	input  wire logic i_mclk,     // block clock
	input  wire logic i_reset_n,  // async reset, active low
	input  wire logic i_pin,      // raw pin level
	output logic      o_level,    // filtered level
	output logic      o_rise      // one-cycle pulse on rising level
);
	advo_pkg::advo_sync_state_s st_reg;  // current state
	advo_pkg::advo_sync_state_s st_next; // next state

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// level only changes once stages two and three agree
	always_comb
	begin
		st_next        = st_reg;
		st_next.s1     = i_pin;
		st_next.s2     = st_reg.s1;
		st_next.s3     = st_reg.s2;
		st_next.edge_p = 1'b0;
		if (st_reg.s2 == st_reg.s3)
		begin
			st_next.level  = st_reg.s3;
			st_next.edge_p = st_reg.s3 & ~st_reg.level;
		end
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign o_level = st_reg.level;
	assign o_rise  = st_reg.edge_p;
endmodule : advo_pin_sync
`default_nettype wire

// *** src/advo_axis_acc.sv ***
// per-axis sum of primary words over one processing cycle, then a
// sequential signed divide by the sample count
// assumes i_add pulses come no faster than one per 34 cycles at a cycle end
`timescale 1ns/1ns
`default_nettype none
module advo_axis_acc (
	input  wire logic        i_mclk,     // block clock
	input  wire logic        i_reset_n,  // async reset, active low
	input  wire logic        i_add,      // add i_value to the sum
	input  wire logic        i_last,     // with i_add: close cycle and divide
	input  wire logic [15:0] i_value,    // primary word of this sample
	input  wire logic [16:0] i_divisor,  // samples per cycle
	output logic             o_done,     // one-cycle pulse, result valid
	output logic [15:0]      o_result    // signed mean, held
);
	advo_pkg::advo_acc_state_s st_reg;  // current state
	advo_pkg::advo_acc_state_s st_next; // next state
	logic signed [32:0]        total;   // sum including this sample
	logic [17:0]               shifted; // partial remainder

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		total        = st_reg.acc + {{17{i_value[15]}}, i_value};
		shifted      = {st_reg.rem, st_reg.quot[31]};
		// accumulate; the last sample starts the divide
		if (i_add && !st_reg.busy)
		begin
			if (i_last)
			begin
				st_next.acc     = '0;
				st_next.neg     = total[32];
				st_next.quot    = total[32] ? 32'(-total) : total[31:0];
				st_next.rem     = '0;
				st_next.divisor = i_divisor;
				st_next.steps   = '0;
				st_next.busy    = 1'b1;
			end
			else
				st_next.acc = total;
		end
		// one restoring step per cycle
		if (st_reg.busy)
		begin
			st_next.quot = {st_reg.quot[30:0], 1'b0};
			if (shifted >= {1'b0, st_reg.divisor})
			begin
				st_next.rem     = 17'(shifted - {1'b0, st_reg.divisor});
				st_next.quot[0] = 1'b1;
			end
			else
				st_next.rem = shifted[16:0];
			st_next.steps = 6'(st_reg.steps + 6'h01);
			if (st_reg.steps == 6'(advo_pkg::DIV_STEPS - 1))
			begin
				st_next.busy   = 1'b0;
				st_next.done   = 1'b1;
				st_next.result = st_reg.neg ? 16'(-st_next.quot[15:0]) : st_next.quot[15:0];
			end
		end
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign o_done   = st_reg.done;
	assign o_result = st_reg.result;
endmodule : advo_axis_acc
`default_nettype wire

// *** src/unused_placeholder_none.sv ***
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** tb/advo_host_model.sv ***
// host-side reader model for the acceleration and velocity output registers
// assumes requests are taken on the rising edge and answered one cycle later
`timescale 1ns/1ns
`default_nettype none
module advo_host_model (
	input  wire logic        i_mclk,       // block clock
	input  wire logic [15:0] i_rd_data,    // read data from the block
	input  wire logic        i_rd_valid,   // read answer pulse
	output logic             o_rd_strobe,  // read request
	output logic [6:0]       o_rd_addr,    // read offset
	output logic             o_wr_strobe,  // write request
	output logic [6:0]       o_wr_addr,    // write offset
	output logic [15:0]      o_wr_data     // write data
);
	// ----------------------------------------------------------------
	// idle levels at time zero
	// ----------------------------------------------------------------
	initial
	begin
		o_rd_strobe = 1'b0;
		o_rd_addr   = 7'h00;
		o_wr_strobe = 1'b0;
		o_wr_addr   = 7'h00;
		o_wr_data   = 16'h0000;
	end
	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	// one read: request held over one rising edge, answer taken one cycle on
	task automatic rd(input logic [6:0] addr, output logic [15:0] data, output logic vld);
		@(negedge i_mclk);
		o_rd_strobe = 1'b1;
		o_rd_addr   = addr;
		@(negedge i_mclk);
		vld         = i_rd_valid;
		data        = i_rd_data;
		o_rd_strobe = 1'b0;
		o_rd_addr   = ~addr;  // released offset no longer shows the old value
	endtask : rd
	// one write: the block is expected to ignore it
	task automatic wr(input logic [6:0] addr, input logic [15:0] data);
		@(negedge i_mclk);
		o_wr_strobe = 1'b1;
		o_wr_addr   = addr;
		o_wr_data   = data;
		@(negedge i_mclk);
		o_wr_strobe = 1'b0;
		o_wr_addr   = ~addr;
		o_wr_data   = ~data;
	endtask : wr
	// reads one axis and builds the full and the truncated sample
	task automatic rd_axis(input logic [6:0] ext_ofs, input logic [6:0] prim_ofs,
		output logic [31:0] full, output logic [17:0] narrow);
		logic [15:0] ext;
		logic [15:0] prim;
		logic        vld;
		rd(ext_ofs, ext, vld);
		rd(prim_ofs, prim, vld);
		full   = {prim, ext};         // primary on top, lsb = scale / 2^16
		narrow = {prim, ext[15:14]};  // top two extension bits kept below the primary
	endtask : rd_axis
endmodule : advo_host_model
`default_nettype wire

// *** tb/advo_outputs_tb.sv ***
// self-checking testbench for the acceleration and velocity output block
// assumes the host model in advo_host_model.sv and a shortened sample period
`timescale 1ns/1ns
`default_nettype none
module advo_outputs_tb;
	localparam int unsigned P_CYC = 64;  // shortened internal sample period
	logic                 i_mclk;        // 250 MHz clock
	logic                 i_reset_n;     // async reset, active low
	advo_pkg::advo_axis_s ax_in [3];     // filtered samples x, y, z
	logic [15:0]          dec_set;       // decimation setting
	logic [15:0]          misc_ctl;      // select in [3:2]
	logic                 ext_pin;       // external sample clock
	logic                 rd_strobe;     // host read request
	logic [6:0]           rd_addr;       // host read offset
	logic                 wr_strobe;     // host write request
	logic [6:0]           wr_addr;       // host write offset
	logic [15:0]          wr_data;       // host write data
	logic [15:0]          rd_data;       // block read data
	logic                 rd_valid;      // block read answer
	logic                 o_update;      // block refresh pulse
	int                   miscompares;   // mismatches
	int                   checks;        // comparisons made
	logic [6:0] ext_ofs [3] = '{advo_pkg::OFS_ACCEL_X_EXTENSION, advo_pkg::OFS_ACCEL_Y_EXTENSION,
		advo_pkg::OFS_ACCEL_Z_EXTENSION};
	logic [6:0] prim_ofs [3] = '{advo_pkg::OFS_ACCEL_X_PRIMARY, advo_pkg::OFS_ACCEL_Y_PRIMARY,
		advo_pkg::OFS_ACCEL_Z_PRIMARY};
	logic [6:0] vel_ofs [3] = '{advo_pkg::OFS_VELOCITY_STEP_X, advo_pkg::OFS_VELOCITY_STEP_Y,
		advo_pkg::OFS_VELOCITY_STEP_Z};
	// ----------------------------------------------------------------
	// instances
	// ----------------------------------------------------------------
	advo_outputs #(.P_INT_SAMPLE_CYCLES(P_CYC)) advo_outputs_i (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_accel_x(ax_in[0]), .i_accel_y(ax_in[1]),
		.i_accel_z(ax_in[2]), .i_decimation_setting(dec_set), .i_misc_control_register(misc_ctl),
		.i_ext_sample_clk(ext_pin), .i_rd_strobe(rd_strobe), .i_rd_addr(rd_addr), .i_wr_strobe(wr_strobe),
		.i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
		.o_update(o_update));
	advo_host_model advo_host_model_i (
		.i_mclk(i_mclk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_rd_strobe(rd_strobe),
		.o_rd_addr(rd_addr), .o_wr_strobe(wr_strobe), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
	// ----------------------------------------------------------------
	// clock and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	// cuts a hang short well past the expected run length
	initial
	begin
		repeat (20000) @(posedge i_mclk);
		miscompares++;
		end_sim();
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// compares one value and counts the outcome
	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// waits for the refresh pulse, at most lim cycles, returns cycles waited
	task automatic wait_upd(input int lim, output int n);
		@(negedge i_mclk);
		n = 1;
		while (o_update !== 1'b1 && n < lim)
		begin
			@(negedge i_mclk);
			n++;
		end
		chk("update seen", {31'h0, o_update}, 32'h1);
	endtask : wait_upd
	// reads every output register and compares with the live inputs or zero
	task automatic check_regs(input bit zero);
		logic [15:0] d;
		logic        v;
		logic [31:0] full;
		logic [17:0] nar;
		for (int a = 0; a < 3; a++)
		begin
			advo_host_model_i.rd_axis(ext_ofs[a], prim_ofs[a], full, nar);
			chk("combined word", full, zero ? 32'h0 : {ax_in[a].primary, ax_in[a].extension});
			chk("narrow word", {14'h0, nar}, zero ? 32'h0 : {14'h0, ax_in[a].primary, ax_in[a].extension[15:14]});
			advo_host_model_i.rd(vel_ofs[a], d, v);
			chk("velocity step", {15'h0, v, d}, {15'h0, 1'b1, zero ? 16'h0 : ax_in[a].primary});
		end
		advo_host_model_i.rd(7'h1E, d, v);
		chk("unmapped read", {15'h0, v, d}, {15'h0, 1'b1, advo_pkg::UNMAPPED_READ});
	endtask : check_regs
	// one rising edge on the external sample pin
	task automatic ext_edge();
		ext_pin = 1'b1;
		repeat (6) @(negedge i_mclk);
		ext_pin = 1'b0;
	endtask : ext_edge
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// internal clock, one sample per cycle, positive and negative values
	task automatic t_internal();
		int n;
		ax_in[0] = {16'h4E20, 16'hC000};
		ax_in[1] = {16'hB1E0, 16'h4000};
		ax_in[2] = {16'h0001, 16'h8001};
		wait_upd(300, n);
		wait_upd(300, n);
		chk("internal period", 32'(n), 32'(P_CYC));
		check_regs(1'b0);
	endtask : t_internal
	// decimation of four: cycle spans four internal samples
	task automatic t_decim();
		int n;
		dec_set  = 16'h0003;
		ax_in[0] = {16'hFFFF, 16'h1234};
		ax_in[1] = {16'h8000, 16'hFFFF};
		ax_in[2] = {16'h7FFF, 16'h0000};
		wait_upd(1000, n);
		wait_upd(1000, n);
		wait_upd(1000, n);
		chk("decimated period", 32'(n), 32'(4 * P_CYC));
		check_regs(1'b0);
	endtask : t_decim
	// writes to every output offset leave the contents alone
	task automatic t_readonly();
		for (int a = 0; a < 3; a++)
		begin
			advo_host_model_i.wr(ext_ofs[a], 16'hA5A5);
			advo_host_model_i.wr(prim_ofs[a], 16'h5A5A);
			advo_host_model_i.wr(vel_ofs[a], 16'hA5A5);
		end
		check_regs(1'b0);
	endtask : t_readonly
	// every external select code: only pin edges count, two per cycle
	task automatic t_external();
		int   n;
		logic seen;
		dec_set = 16'h0001;
		wait_upd(300, n);
		wait_upd(300, n);
		for (int s = 1; s < 4; s++)
		begin
			misc_ctl = 16'(s << advo_pkg::SEL_LSB);
			ax_in[0] = {16'(16'h0100 * s), 16'h00F0};
			ext_edge();
			// one pin edge of two must not close the cycle
			seen = 1'b0;
			repeat (150)
			begin
				@(negedge i_mclk);
				seen = seen | o_update;
			end
			chk("early update", {31'h0, seen}, 32'h0);
			ext_edge();
			wait_upd(60, n);
			chk("external update", {31'h0, o_update}, 32'h1);
			check_regs(1'b0);
		end
	endtask : t_external
	// ----------------------------------------------------------------
	// verdict
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		miscompares = 0;
		checks      = 0;
		i_reset_n   = 1'b0;
		ax_in[0]    = {16'h1111, 16'h2222};
		ax_in[1]    = {16'h3333, 16'h4444};
		ax_in[2]    = {16'h5555, 16'h6666};
		dec_set     = 16'h0000;
		misc_ctl    = 16'h0000;
		ext_pin     = 1'b0;
		repeat (8) @(negedge i_mclk);
		i_reset_n = 1'b1;
		check_regs(1'b1);
		t_internal();
		t_decim();
		t_readonly();
		t_external();
		end_sim();
	end
endmodule : advo_outputs_tb
`default_nettype wire
